// [external_memory_bus_interface.sv]
`timescale 1ns/100ps
`default_nettype none
module external_memory_bus_interface #(
  parameter int ALE_CYCLES    = ext_bus_pkg::ALE_CYC,
  parameter int STROBE_CYCLES = ext_bus_pkg::STROBE_CYC
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // apb slave
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // external pins
  input  wire logic                   resetPinN,
  input  wire logic                   processorModePin,
  input  wire logic                   byteWidthPin,
  input  wire logic                   holdRequestN,
  input  wire logic                   readyN,
  input  wire logic                   subClock,
  output var  ext_bus_pkg::ext_pins_s busPins,
  output var  logic                   busPinsOe,
  input  wire logic [15:0]            dataIn,
  output var  logic [15:0]            dataOut,
  output var  logic [15:0]            dataOe,
  output var  logic                   holdAcknowledgeN,
  output var  logic                   clockOutputPin,
  output var  logic                   busClock
);
  // elaboration check on timing parameters
  if (ALE_CYCLES < 1 || ALE_CYCLES > 15 || STROBE_CYCLES < 3 || STROBE_CYCLES > 15) begin : g_badParam
    $error("phase cycle counts must be 1..15 (strobe at least 3)");
  end

  // two-flop synchronisers: pins and sub clock
  logic [5:0]  syncA_reg;
  logic [5:0]  syncB_reg;
  logic [15:0] dataA_reg;
  logic [15:0] dataB_reg;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_reg <= 6'h3F;
      syncB_reg <= 6'h3F;
      dataA_reg <= 16'h0000;
      dataB_reg <= 16'h0000;
    end else begin
      syncA_reg <= {resetPinN, processorModePin, byteWidthPin, holdRequestN, readyN, subClock};
      syncB_reg <= syncA_reg;
      dataA_reg <= dataIn;
      dataB_reg <= dataA_reg;
    end
  end

  // named views of synchronised pins
  wire logic rstPinLow = ~syncB_reg[5];
  wire logic modeSync  = syncB_reg[4];
  wire logic width8    = syncB_reg[3];
  wire logic holdLow   = ~syncB_reg[2];
  wire logic readyLow  = ~syncB_reg[1];
  wire logic subSync   = syncB_reg[0];

  // processor mode latched once the pins settle after any reset
  logic [1:0] settleCnt_reg;
  logic       modeValid_reg;
  logic       mpMode_reg;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      settleCnt_reg <= 2'h0;
      modeValid_reg <= 1'b0;
      mpMode_reg    <= 1'b0;
    end else if (rstPinLow) begin
      settleCnt_reg <= 2'h0;
      modeValid_reg <= 1'b0;
    end else if (!modeValid_reg) begin
      settleCnt_reg <= settleCnt_reg + 2'h1;
      if (settleCnt_reg == 2'(ext_bus_pkg::MODE_SETTLE_CYC - 1)) begin
        modeValid_reg <= 1'b1;
        mpMode_reg    <= modeSync;
      end
    end
  end

  // bus usable only in microprocessor mode out of reset
  wire logic busUsable = modeValid_reg & mpMode_reg & ~rstPinLow;

  // software registers
  ext_bus_pkg::ctrl_s ctrl_reg;
  logic [19:0] reqAddr_reg;
  logic [15:0] reqData_reg;
  logic        reqWrite_reg;
  logic        reqWord_reg;
  logic [15:0] rdData_reg;
  logic        start_reg;
  ext_bus_pkg::bus_state_e state_reg;
  ext_bus_pkg::bus_state_e stateNext;
  logic [3:0]  phaseCnt_reg;

  // apb decode
  wire logic setup    = psel & ~penable;
  wire logic access   = psel & penable;
  wire logic hitCtrl  = (paddr == ext_bus_pkg::CTRL_OFS);
  wire logic hitAddr  = (paddr == ext_bus_pkg::ADDR_OFS);
  wire logic hitWdata = (paddr == ext_bus_pkg::WDATA_OFS);
  wire logic hitCmd   = (paddr == ext_bus_pkg::CMD_OFS);
  wire logic hitStat  = (paddr == ext_bus_pkg::STATUS_OFS);
  wire logic hitRdata = (paddr == ext_bus_pkg::RDATA_OFS);
  wire logic mapped   = hitCtrl | hitAddr | hitWdata | hitCmd | hitStat | hitRdata;
  wire logic busBusy  = (state_reg != ext_bus_pkg::ST_IDLE) | start_reg;
  wire logic cmdBad   = hitCmd & (~pwrite | busBusy | ~busUsable);
  wire logic regLock  = busBusy & (hitAddr | hitWdata | hitCtrl) & pwrite;
  wire logic wrOk     = access & pwrite & mapped & ~cmdBad & ~regLock;

  assign pready  = 1'b1;
  assign pslverr = access & (~mapped | cmdBad | regLock);

  // single strobe style forced on an 8-bit bus
  wire logic singleEff = ctrl_reg.singleStrobe | width8;

  // status word
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ext_bus_pkg::ST_BUSY_BIT]   = busBusy;
    statusWord[ext_bus_pkg::ST_HOLD_BIT]   = (state_reg == ext_bus_pkg::ST_HOLD);
    statusWord[ext_bus_pkg::ST_BYTE8_BIT]  = width8;
    statusWord[ext_bus_pkg::ST_MPMODE_BIT] = mpMode_reg & modeValid_reg;
    statusWord[ext_bus_pkg::ST_SINGLE_BIT] = singleEff;
    statusWord[ext_bus_pkg::ST_RSTPIN_BIT] = rstPinLow;
    statusWord[ext_bus_pkg::ST_READY_BIT]  = busUsable;
  end

  // read mux
  wire logic [31:0] readWord =
    hitCtrl  ? {24'h00_0000, ctrl_reg} :
    hitAddr  ? {12'h000, reqAddr_reg} :
    hitWdata ? {16'h0000, reqData_reg} :
    hitStat  ? statusWord :
    hitRdata ? {16'h0000, rdData_reg} : 32'h0000_0000;

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= readWord;
    end
  end

  // control register, locked while an access runs
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= ext_bus_pkg::CTRL_RESET;
    end else if (wrOk & hitCtrl) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // external address of the next access
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqAddr_reg <= 20'h0_0000;
    end else if (wrOk & hitAddr) begin
      reqAddr_reg <= pwdata[19:0];
    end
  end

  // write data of the next access
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqData_reg <= 16'h0000;
    end else if (wrOk & hitWdata) begin
      reqData_reg <= pwdata[15:0];
    end
  end

  // direction and size taken with the command
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqWrite_reg <= 1'b0;
      reqWord_reg  <= 1'b0;
    end else if (wrOk & hitCmd) begin
      reqWrite_reg <= pwdata[ext_bus_pkg::CMD_WRITE_BIT];
      reqWord_reg  <= pwdata[ext_bus_pkg::CMD_WORD_BIT];
    end
  end

  // start flag: set by a command, cleared once the address phase begins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_reg <= 1'b0;
    end else if (wrOk & hitCmd) begin
      start_reg <= 1'b1;
    end else if (state_reg == ext_bus_pkg::ST_ADDR) begin
      start_reg <= 1'b0;
    end
  end

  // lane selection for the request
  wire logic       oddAddr = reqAddr_reg[0];
  wire logic       effWord = reqWord_reg & ~width8 & ~oddAddr;
  wire logic       loLane  = width8 | ~oddAddr;
  wire logic       hiLane  = ~width8 & (oddAddr | effWord);
  wire logic       bheAct  = oddAddr | effWord;
  wire logic [7:0] muxAddr = width8 ? reqAddr_reg[7:0] : reqAddr_reg[8:1];
  wire logic [7:0] hiWrite = effWord ? reqData_reg[15:8] : reqData_reg[7:0];
  wire logic [15:0] wrData = {hiLane ? hiWrite : 8'h00, loLane ? reqData_reg[7:0] : 8'h00};
  wire logic       phaseDone = (phaseCnt_reg == 4'h0);

  // bus sequencer next state
  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      ext_bus_pkg::ST_IDLE: begin
        if (!busUsable) begin
          stateNext = ext_bus_pkg::ST_IDLE;
        end else if (holdLow) begin
          stateNext = ext_bus_pkg::ST_HOLD;
        end else if (start_reg) begin
          stateNext = ext_bus_pkg::ST_ADDR;
        end
      end
      ext_bus_pkg::ST_ADDR: begin
        if (phaseDone) begin
          stateNext = ext_bus_pkg::ST_STROBE;
        end
      end
      ext_bus_pkg::ST_STROBE: begin
        if (phaseDone && !readyLow) begin
          stateNext = ext_bus_pkg::ST_IDLE;
        end
      end
      ext_bus_pkg::ST_HOLD: begin
        if (!holdLow || !busUsable) begin
          stateNext = ext_bus_pkg::ST_IDLE;
        end
      end
      default: stateNext = ext_bus_pkg::ST_IDLE;
    endcase
    if (rstPinLow) begin
      stateNext = ext_bus_pkg::ST_IDLE;
    end
  end

  // counter load for a phase that lasts the given number of cycles
  function automatic logic [3:0] phaseLoad(input int cycles);
    return 4'(cycles - 1);
  endfunction

  // phase entry and read completion events
  wire logic enterAddr   = (stateNext == ext_bus_pkg::ST_ADDR) & (state_reg != ext_bus_pkg::ST_ADDR);
  wire logic enterStrobe = (stateNext == ext_bus_pkg::ST_STROBE) & (state_reg != ext_bus_pkg::ST_STROBE);
  wire logic readDone    = (state_reg == ext_bus_pkg::ST_STROBE) & (stateNext == ext_bus_pkg::ST_IDLE) & ~reqWrite_reg;
  wire logic [15:0] readLanes = width8  ? {8'h00, dataB_reg[7:0]} :
                                oddAddr ? {8'h00, dataB_reg[15:8]} :
                                effWord ? dataB_reg : {8'h00, dataB_reg[7:0]};

  // sequencer state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ext_bus_pkg::ST_IDLE;
    end else begin
      state_reg <= stateNext;
    end
  end

  // phase counter: latch strobe length, then strobe length
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseCnt_reg <= 4'h0;
    end else if (enterAddr) begin
      phaseCnt_reg <= phaseLoad(ALE_CYCLES);
    end else if (enterStrobe) begin
      phaseCnt_reg <= phaseLoad(STROBE_CYCLES);
    end else if (!phaseDone) begin
      phaseCnt_reg <= phaseCnt_reg - 4'h1;
    end
  end

  // read data taken from the synchronised pins as the strobe ends
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg <= 16'h0000;
    end else if (readDone) begin
      rdData_reg <= readLanes;
    end
  end

  // next pin values from the next state
  wire logic nAddr   = (stateNext == ext_bus_pkg::ST_ADDR);
  wire logic nStrobe = (stateNext == ext_bus_pkg::ST_STROBE);
  wire logic nActive = nAddr | nStrobe;
  wire logic nWrite  = nStrobe & reqWrite_reg;
  wire logic nRead   = nStrobe & ~reqWrite_reg;
  wire logic [1:0] region = reqAddr_reg[19:18];
  ext_bus_pkg::ext_pins_s pinsNext;
  logic [15:0] dOutNext;
  logic [15:0] dOeNext;
  always_comb begin
    pinsNext.addr            = nActive ? reqAddr_reg : 20'h0_0000;
    pinsNext.addrLatchStrobe = nAddr;
    pinsNext.readStrobeN     = ~nRead;
    if (singleEff) begin
      pinsNext.lowByteWriteStrobeN  = ~nWrite;
      pinsNext.highByteWriteStrobeN = ~(nStrobe & bheAct);
    end else begin
      pinsNext.lowByteWriteStrobeN  = ~(nWrite & ~oddAddr);
      pinsNext.highByteWriteStrobeN = ~(nWrite & hiLane);
    end
    for (int i = 0; i < 4; i++) begin
      pinsNext.chipSelectN[i] = ~(nActive & ctrl_reg.csEnable[i] & (region == 2'(i)));
    end
    dOutNext = 16'h0000;
    dOeNext  = 16'h0000;
    if (nAddr & ctrl_reg.muxBus) begin
      dOutNext = {8'h00, muxAddr};
      dOeNext  = 16'h00FF;
    end else if (nWrite) begin
      dOutNext = wrData;
      dOeNext  = {{8{hiLane}}, {8{loLane}}};
    end
  end

  // registered bus pins; the latch strobe idles low, the other strobes high
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busPins   <= '{addr: 20'h0_0000, chipSelectN: 4'hF, addrLatchStrobe: 1'b0, default: 1'b1};
      busPinsOe <= 1'b0;
    end else begin
      busPins   <= pinsNext;
      busPinsOe <= busUsable & (stateNext != ext_bus_pkg::ST_HOLD);
    end
  end

  // registered data pins and their enables
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOut <= 16'h0000;
      dataOe  <= 16'h0000;
    end else begin
      dataOut <= dOutNext;
      dataOe  <= dOeNext;
    end
  end

  // hold acknowledge follows the hold state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdAcknowledgeN <= 1'b1;
    end else begin
      holdAcknowledgeN <= (stateNext != ext_bus_pkg::ST_HOLD);
    end
  end

  // clock output and bus clock dividers
  logic [4:0] divCnt_reg;
  wire logic clkSelNext =
    (ctrl_reg.clockSel == ext_bus_pkg::CLKSEL_DIV8)  ? divCnt_reg[2] :
    (ctrl_reg.clockSel == ext_bus_pkg::CLKSEL_DIV32) ? divCnt_reg[4] : subSync;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_reg <= 5'h00;
    end else begin
      divCnt_reg <= divCnt_reg + 5'h01;
    end
  end

  // clock output: sub clock or a divided tap
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clockOutputPin <= 1'b0;
    end else begin
      clockOutputPin <= clkSelNext;
    end
  end

  // bus clock toggles every cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busClock <= 1'b0;
    end else begin
      busClock <= ~busClock;
    end
  end
endmodule
`default_nettype wire

// [ext_bus_pkg.sv]
// Overview of operation
// - separate bus uses low lanes, high if 16-bit
// - twenty address lines, bit zero to nineteen
// - 8-bit mux: address 7..0 then data
// - 16-bit mux: address 8..1 then data
// - four active-low chip selects, one per region
// - software picks split or single write strobe
// - split style: low strobe on even write
// - split style: high strobe on odd write
// - read strobe low while reading external space
// - single style: write strobe on every write
// - single style: byte-high enable on odd access
// - 8-bit bus forces single strobe style
// - address latch strobe output for external latch
// - hold request low keeps device in hold
// - hold acknowledge low while in hold
// - ready low keeps device in wait state
// - device stays reset while reset pin low
// - clock output: sub clock, div eight, div 32
// - bus clock driven on its own output
`default_nettype none
package ext_bus_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] ADDR_OFS   = 12'h004;
  localparam logic [11:0] WDATA_OFS  = 12'h008;
  localparam logic [11:0] CMD_OFS    = 12'h00C;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam logic [11:0] RDATA_OFS  = 12'h014;
  // field positions
  localparam int CMD_WRITE_BIT  = 0;
  localparam int CMD_WORD_BIT   = 1;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_HOLD_BIT    = 1;
  localparam int ST_BYTE8_BIT   = 2;
  localparam int ST_MPMODE_BIT  = 3;
  localparam int ST_SINGLE_BIT  = 4;
  localparam int ST_RSTPIN_BIT  = 5;
  localparam int ST_READY_BIT   = 6;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'hF0;
  // clock output selections
  localparam logic [1:0] CLKSEL_SUB   = 2'h0;
  localparam logic [1:0] CLKSEL_DIV8  = 2'h1;
  localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int ALE_MIN_NS     = 100;
  localparam int STROBE_MIN_NS  = 300;
  localparam int ALE_CYC    = (ALE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV8       = 8;
  localparam int DIV32      = 32;
  localparam int MODE_SETTLE_CYC = 3;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_HOLD} bus_state_e;

  typedef struct packed {
    logic [3:0] csEnable;
    logic [1:0] clockSel;
    logic       muxBus;
    logic       singleStrobe;
  } ctrl_s;

  // lowByteWriteStrobeN doubles as the single write strobe and
  // highByteWriteStrobeN as byteHighEnableN in single-strobe style
  typedef struct packed {
    logic [19:0] addr;
    logic [3:0]  chipSelectN;
    logic        readStrobeN;
    logic        lowByteWriteStrobeN;
    logic        highByteWriteStrobeN;
    logic        addrLatchStrobe;
  } ext_pins_s;
endpackage
`default_nettype wire

// [ext_bus_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module ext_bus_checker #(
  parameter int ALE_CYCLES = 1
) (
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  input wire logic                   resetPinN,
  input wire logic                   holdRequestN,
  input wire logic                   readyN,
  input wire ext_bus_pkg::ext_pins_s busPins,
  input wire logic                   busPinsOe,
  input wire logic [15:0]            dataOe,
  input wire logic                   holdAcknowledgeN,
  input wire logic                   busClock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // bus pin relations
  chk_cs_decode: assert property (busPins.chipSelectN != 4'hF |-> busPins.chipSelectN == ~(4'h1 << busPins.addr[19:18]))
    else $error("chip select outside its region");
  chk_ale_width: assert property ($rose(busPins.addrLatchStrobe) |-> ##ALE_CYCLES !busPins.addrLatchStrobe)
    else $error("latch strobe width wrong");
  chk_ale_quiet: assert property (busPins.addrLatchStrobe |-> busPins.readStrobeN && busPins.lowByteWriteStrobeN && busPinsOe)
    else $error("strobe during address phase");
  chk_read_min: assert property ($fell(busPins.readStrobeN) |-> !busPins.readStrobeN [*3])
    else $error("read strobe too short");
  chk_read_quiet: assert property (!busPins.readStrobeN |-> dataOe == 16'h0000 && busPins.lowByteWriteStrobeN)
    else $error("data driven during read");
  chk_write_drive: assert property (!busPins.lowByteWriteStrobeN |-> dataOe != 16'h0000)
    else $error("write strobe without data");
  chk_ready_wait: assert property ((!readyN [*3]) ##0 !busPins.readStrobeN |=> !busPins.readStrobeN)
    else $error("strobe ended while waiting");
  chk_hold_float: assert property (!holdAcknowledgeN |-> !busPinsOe && dataOe == 16'h0000)
    else $error("bus driven in hold");
  chk_hold_end: assert property ($rose(holdRequestN) |-> ##[1:4] holdAcknowledgeN)
    else $error("hold not left");
  chk_reset_pin: assert property ((!resetPinN [*4]) |-> !busPinsOe && dataOe == 16'h0000)
    else $error("bus driven in reset");
  chk_bus_clock: assert property (!$past(sys_rst, 2) && !$past(sys_rst) |-> busClock != $past(busClock))
    else $error("bus clock stuck");
  // main scenarios
  cover property ($fell(holdAcknowledgeN));
  cover property ((!readyN [*3]) ##0 !busPins.readStrobeN);
  cover property ($fell(busPins.lowByteWriteStrobeN));
endmodule
bind external_memory_bus_interface ext_bus_checker #(.ALE_CYCLES(ALE_CYCLES)) u_chk (.ref_clk, .sys_rst, .resetPinN,
  .holdRequestN, .readyN, .busPins, .busPinsOe, .dataOe, .holdAcknowledgeN, .busClock);
`default_nettype wire

// [ext_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
  input  wire logic                   ref_clk,
  input  wire ext_bus_pkg::ext_pins_s busPins,
  input  wire logic [15:0]            dataOut,
  input  wire logic                   splitStyle,
  input  wire logic [3:0]             stallCyc,
  output var  logic [15:0]            dataIn,
  output var  logic                   readyN,
  output var  logic [7:0]             muxSeen
);
  logic [7:0]  loMem [128];
  logic [7:0]  hiMem [128];
  logic [3:0]  waitCnt = 4'h0;
  logic [15:0] lastRead = 16'h0000;
  // lane enables for both strobe styles
  wire logic [6:0] idx  = busPins.addr[7:1];
  wire logic       wrN  = busPins.lowByteWriteStrobeN;
  wire logic       hiN  = busPins.highByteWriteStrobeN;
  wire logic       loWr = splitStyle ? !wrN : (!wrN && !busPins.addr[0]);
  wire logic       hiWr = splitStyle ? !hiN : (!wrN && !hiN);
  wire logic       act  = !busPins.readStrobeN || !wrN || (splitStyle && !hiN);
  // stretch each strobe by stallCyc; released lines show the inverse of the last read
  assign readyN = !(act && waitCnt != 4'h0);
  assign dataIn = !busPins.readStrobeN ? {hiMem[idx], loMem[idx]} : ~lastRead;
  // capture written lanes and the multiplexed address
  always @(posedge ref_clk) begin
    if (loWr) loMem[idx] <= dataOut[7:0];
    if (hiWr) hiMem[idx] <= dataOut[15:8];
    if (busPins.addrLatchStrobe) muxSeen <= dataOut[7:0];
    if (!busPins.readStrobeN) lastRead <= dataIn;
    waitCnt <= act ? waitCnt - 4'(waitCnt != 4'h0) : stallCyc;
  end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                   ref_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic [11:0]            paddr = 12'h000;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [31:0]            pwdata = 32'h00000000;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   resetPinN = 1'b1;
  logic                   processorModePin = 1'b1;
  logic                   byteWidthPin = 1'b0;
  logic                   holdRequestN = 1'b1;
  logic                   readyN;
  logic                   subClock = 1'b0;
  ext_bus_pkg::ext_pins_s busPins;
  logic                   busPinsOe;
  logic [15:0]            dataIn;
  logic [15:0]            dataOut;
  logic [15:0]            dataOe;
  logic                   holdAcknowledgeN;
  logic                   clockOutputPin;
  logic                   busClock;
  logic                   splitStyle = 1'b1;
  logic [3:0]             stallCyc = 4'h0;
  logic [7:0]             muxSeen;
  logic [31:0]            rd;
  logic                   slvErr;
  logic [19:0]            a;
  logic                   prev;
  int                     n;
  int                     errors = 0;
  int                     n_compared = 0;
  localparam int SUB_CYC = 14; // sub clock period in ref_clk cycles
  // clocks
  always #50 ref_clk = ~ref_clk;
  always #(SUB_CYC * 50) subClock = ~subClock;
  external_memory_bus_interface u_dut (.ref_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .resetPinN, .processorModePin, .byteWidthPin, .holdRequestN, .readyN, .subClock, .busPins,
    .busPinsOe, .dataIn, .dataOut, .dataOe, .holdAcknowledgeN, .clockOutputPin, .busClock);
  ext_mem_model u_mem (.ref_clk, .busPins, .dataOut, .splitStyle, .stallCyc, .dataIn, .readyN, .muxSeen);
  // one apb transfer, held until pready
  task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // external access, poll busy, then fetch read data
  task automatic ext(input logic [19:0] ad, input logic [1:0] cmd, input logic [15:0] d);
    int k;
    apb(ext_bus_pkg::ADDR_OFS, 1'b1, {12'h000, ad});
    apb(ext_bus_pkg::WDATA_OFS, 1'b1, {16'h0000, d});
    apb(ext_bus_pkg::CMD_OFS, 1'b1, {30'h0, cmd});
    k = 0;
    rd = 32'h00000001;
    while (rd[ext_bus_pkg::ST_BUSY_BIT] !== 1'b0 && k < 100) begin
      apb(ext_bus_pkg::STATUS_OFS, 1'b0, 32'h0);
      k++;
    end
    if (rd[ext_bus_pkg::ST_BUSY_BIT] !== 1'b0) begin
      errors++;
      $display("unexpected at %0t: access never finished", $time);
    end
    apb(ext_bus_pkg::RDATA_OFS, 1'b0, 32'h0);
  endtask
  task automatic end_sim();
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #2000000;
    errors++;
    end_sim();
  end
  // test sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    apb(ext_bus_pkg::CTRL_OFS, 1'b0, 32'h0);
    chk(rd, {24'h0, ext_bus_pkg::CTRL_RESET});
    apb(ext_bus_pkg::STATUS_OFS, 1'b0, 32'h0);
    chk(rd, 32'h48);
    apb(12'h018, 1'b0, 32'h0);
    chk({31'h0, slvErr}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      stallCyc <= 4'(i * 2);
      a = {2'(i), 18'h00010};
      ext(a, 2'b01, {2{8'hA5 + 8'(i)}});
      ext(a + 20'h1, 2'b01, 16'h3C3C);
      ext(a, 2'b10, 16'h0000);
      chk(rd, {16'h0, 8'h3C, 8'hA5 + 8'(i)});
    end
    stallCyc <= 4'h0;
    apb(ext_bus_pkg::CTRL_OFS, 1'b1, 32'hF1);
    splitStyle <= 1'b0;
    ext(20'h00040, 2'b11, 16'hBEEF);
    ext(20'h00043, 2'b01, 16'h7777);
    ext(20'h00042, 2'b01, 16'h1111);
    ext(20'h00040, 2'b10, 16'h0000);
    chk(rd, 32'hBEEF);
    ext(20'h00042, 2'b10, 16'h0000);
    chk(rd, 32'h7711);
    apb(ext_bus_pkg::CTRL_OFS, 1'b1, 32'hF2);
    splitStyle <= 1'b1;
    ext(20'h00024, 2'b11, 16'h1234);
    chk({24'h0, muxSeen}, 32'h12);
    ext(20'h00024, 2'b10, 16'h0000);
    chk(rd, 32'h1234);
    for (int s = 0; s < 3; s++) begin
      apb(ext_bus_pkg::CTRL_OFS, 1'b1, {24'h0, 4'hF, 2'(s), 2'b00});
      repeat (40) @(posedge ref_clk);
      n = 0;
      prev = clockOutputPin;
      for (int k = 0; k < 224; k++) begin
        @(posedge ref_clk);
        if (clockOutputPin === 1'b1 && prev === 1'b0) n++;
        prev = clockOutputPin;
      end
      chk(32'(n), 32'(224 / (s == 0 ? SUB_CYC : s == 1 ? ext_bus_pkg::DIV8 : ext_bus_pkg::DIV32)));
    end
    holdRequestN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, holdAcknowledgeN}, 32'h0);
    apb(ext_bus_pkg::STATUS_OFS, 1'b0, 32'h0);
    chk({31'h0, rd[ext_bus_pkg::ST_HOLD_BIT]}, 32'h1);
    holdRequestN <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({31'h0, holdAcknowledgeN}, 32'h1);
    byteWidthPin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(ext_bus_pkg::STATUS_OFS, 1'b0, 32'h0);
    chk(rd & 32'h14, 32'h14);
    apb(ext_bus_pkg::CTRL_OFS, 1'b1, 32'hF2);
    splitStyle <= 1'b0;
    ext(20'h00024, 2'b01, 16'h0056);
    chk({24'h0, muxSeen}, 32'h24);
    ext(20'h00024, 2'b00, 16'h0000);
    chk(rd, 32'h56);
    byteWidthPin <= 1'b0;
    resetPinN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(ext_bus_pkg::STATUS_OFS, 1'b0, 32'h0);
    chk(rd & 32'h20, 32'h20);
    chk({31'h0, busPinsOe}, 32'h0);
    processorModePin <= 1'b0;
    resetPinN <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(ext_bus_pkg::STATUS_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(ext_bus_pkg::CMD_OFS, 1'b1, 32'h1);
    chk({31'h0, slvErr}, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
